// ==== src/rscl_cfg.svh ====
// Constants for the reset strap configuration latch
`ifndef RSCL_CFG_SVH
`define RSCL_CFG_SVH

// ----------------------------------------------------------------------------
// Strap field widths and reset values
// ----------------------------------------------------------------------------
`define RSCL_BOOT_W 4
`define RSCL_BOOT_RST 4'h0
`define RSCL_BIT_RST 1'h0

// ----------------------------------------------------------------------------
// Boot mode codes
// ----------------------------------------------------------------------------
`define RSCL_BM_HOST_A 4'h0
`define RSCL_BM_I2C 4'h1
`define RSCL_BM_HOST_C 4'h2
`define RSCL_BM_RSV_A 4'h3
`define RSCL_BM_HOST_E 4'h4
`define RSCL_BM_HOST_B 4'h5
`define RSCL_BM_RSV_B 4'h6
`define RSCL_BM_HOST_D 4'h7
`define RSCL_BM_SPI_LO 4'h8
`define RSCL_BM_SPI_HI 4'hB
`define RSCL_BM_SPI_ALT 4'hC
`define RSCL_BM_RSV_C 4'hD
`define RSCL_BM_RSV_D 4'hE

// ----------------------------------------------------------------------------
// Serial boot timing
// ----------------------------------------------------------------------------
`define RSCL_I2C_MAX_KBPS 400
`define RSCL_I2C_DIV 128
`define RSCL_I2C_CNT_W 7
`define RSCL_I2C_CNT_LAST 7'h7F

`endif

// ==== src/rscl_pkg.sv ====
// Types shared by the reset strap configuration latch
package rscl_pkg;

  // --------------------------------------------------------------------------
  // Boot port selection
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    RSCL_BOOT_HOST,
    RSCL_BOOT_SPI,
    RSCL_BOOT_SPI_ALT,
    RSCL_BOOT_I2C,
    RSCL_BOOT_RSV
  } rscl_boot_t;

  // --------------------------------------------------------------------------
  // Raw strap bundle as seen on the pins
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] boot_mode;
    logic watchdog_enable;
    logic strobe_polarity;
    logic port_width;
  } rscl_strap_t;

endpackage

// ==== src/rscl_boot_decode.sv ====
// Boot mode code decoder for the strap latch
`include "rscl_cfg.svh"

module rscl_boot_decode (
  input wire logic [3:0] boot_mode, // Boot mode strap code
  output rscl_pkg::rscl_boot_t boot_port // Decoded boot port
);

  // --------------------------------------------------------------------------
  // Code classes
  // --------------------------------------------------------------------------
  // Host codes are scattered, so they are listed one by one
  wire is_host = (boot_mode == `RSCL_BM_HOST_A) || (boot_mode == `RSCL_BM_HOST_B) ||
                 (boot_mode == `RSCL_BM_HOST_C) || (boot_mode == `RSCL_BM_HOST_D) ||
                 (boot_mode == `RSCL_BM_HOST_E); // see R6
  wire is_spi = (boot_mode >= `RSCL_BM_SPI_LO) && (boot_mode <= `RSCL_BM_SPI_HI); // see R6
  wire is_spi_alt = (boot_mode == `RSCL_BM_SPI_ALT); // see R7
  wire is_i2c = (boot_mode == `RSCL_BM_I2C); // see R6

  // Anything else, reserved codes included, falls to reserved
  assign boot_port = is_host ? rscl_pkg::RSCL_BOOT_HOST :
                     is_spi ? rscl_pkg::RSCL_BOOT_SPI :
                     is_spi_alt ? rscl_pkg::RSCL_BOOT_SPI_ALT :
                     is_i2c ? rscl_pkg::RSCL_BOOT_I2C : rscl_pkg::RSCL_BOOT_RSV;

endmodule

// ==== src/rscl_strap_latch.sv ====
// Reset strap configuration latch: captures straps at power-on reset release
//
// Notes on behaviour
// R1 - Straps are sampled once, at the edge where power-on reset is released.
// R2 - Captured watchdog strap 0 leaves the watchdog off; 1 enables it.
// R3 - Captured polarity strap 0 makes host strobes active low, 1 active high.
// R4 - Captured width strap 0 selects a 16-bit host port, 1 selects 8-bit.
// R5 - Hard reset pin is open drain both ways; outside drivers also open drain.
// R6 - Boot code decodes to host, software SPI, I2C or reserved classes.
// R7 - Code 1100 boots software SPI over the alternate serial pins.
// R8 - I2C boot runs from a divide-by-128 tick, at most 400 Kbps.
// R9 - Captured values hold, ignoring strap changes, until the next release.
`include "rscl_cfg.svh"

module rscl_strap_latch (
  input wire logic clock, // System clock, 250 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic power_on_reset_n, // Power-on reset input, active low
  input wire logic [3:0] boot_mode_strap, // Boot mode strap pins
  input wire logic watchdog_enable_strap, // Watchdog enable strap
  input wire logic host_strobe_polarity_strap, // Host strobe polarity strap
  input wire logic host_port_width_strap, // Host port width strap
  input wire logic hard_reset_pin_in, // Level seen on hard reset pin
  output logic hard_reset_pin_out, // Driven level, always low
  output logic hard_reset_pin_oe, // High while pulling the pin low
  output logic hard_reset_seen, // Pin observed low, registered
  input wire logic host_strobe_raw, // Host strobe as seen on the pin
  output logic host_strobe_active, // Strobe normalised to active high
  output logic config_valid, // Straps captured since last release
  output logic [3:0] boot_mode, // Captured boot code
  output rscl_pkg::rscl_boot_t boot_port, // Captured boot port class
  output logic boot_alt_pins, // Serial boot uses alternate pins
  output logic watchdog_enable, // Watchdog timer enable
  output logic strobe_active_high, // Host strobes active high
  output logic host_port_8bit, // Host port in 8-bit operation
  output logic i2c_bit_tick // One-cycle tick at input clock / 128
);

  // --------------------------------------------------------------------------
  // Phase of the latch
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    RSCL_IN_RESET,
    RSCL_RUNNING
  } rscl_phase_t;

  rscl_phase_t phase;
  rscl_phase_t next_phase;
  rscl_pkg::rscl_strap_t straps;
  rscl_pkg::rscl_boot_t live_port;
  logic por_seen;
  logic [`RSCL_I2C_CNT_W-1:0] i2c_count;
  logic [7:0] tick_gap;

  // --------------------------------------------------------------------------
  // Release detection and decode
  // --------------------------------------------------------------------------
  // Straps gathered into one bundle; the capture block copies each field into its own register
  assign straps = '{boot_mode: boot_mode_strap, watchdog_enable: watchdog_enable_strap,
                    strobe_polarity: host_strobe_polarity_strap,
                    port_width: host_port_width_strap};
  // Release is the first cycle power-on reset reads high after low
  wire release_edge = power_on_reset_n && !por_seen; // see R1
  wire i2c_run = config_valid && (boot_port == rscl_pkg::RSCL_BOOT_I2C);
  wire i2c_wrap = (i2c_count == `RSCL_I2C_CNT_LAST);

  rscl_boot_decode rscl_boot_decode_inst (
    .boot_mode(boot_mode_strap),
    .boot_port(live_port)
  );

  // Phase follows power-on reset; default guards an illegal code
  always_comb begin
    case (phase)
      RSCL_IN_RESET: next_phase = release_edge ? RSCL_RUNNING : RSCL_IN_RESET;
      RSCL_RUNNING: next_phase = power_on_reset_n ? RSCL_RUNNING : RSCL_IN_RESET;
      default: next_phase = RSCL_IN_RESET;
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Edge history and phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      por_seen <= 1'b0;
      phase <= RSCL_IN_RESET;
    end else begin
      por_seen <= power_on_reset_n;
      phase <= next_phase;
    end
  end

  // Capture only at release; held otherwise, so late strap wiggles are lost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_mode <= `RSCL_BOOT_RST;
      boot_port <= rscl_pkg::RSCL_BOOT_HOST;
      boot_alt_pins <= `RSCL_BIT_RST;
      watchdog_enable <= `RSCL_BIT_RST;
      strobe_active_high <= `RSCL_BIT_RST;
      host_port_8bit <= `RSCL_BIT_RST;
    end else if (release_edge) begin // see R1, R9
      boot_mode <= straps.boot_mode; // see R6
      boot_port <= live_port; // see R6
      boot_alt_pins <= (live_port == rscl_pkg::RSCL_BOOT_SPI_ALT); // see R7
      watchdog_enable <= straps.watchdog_enable; // see R2
      strobe_active_high <= straps.strobe_polarity; // see R3
      host_port_8bit <= straps.port_width; // see R4
    end
  end

  // Valid flag drops with power-on reset, values themselves are kept
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      config_valid <= 1'b0;
    end else begin
      config_valid <= (next_phase == RSCL_RUNNING);
    end
  end

  // Open drain: only ever pull low, while power-on reset is held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hard_reset_pin_out <= 1'b0;
      hard_reset_pin_oe <= 1'b1;
      hard_reset_seen <= 1'b0;
    end else begin
      hard_reset_pin_out <= 1'b0; // see R5
      hard_reset_pin_oe <= !power_on_reset_n; // see R5
      hard_reset_seen <= !hard_reset_pin_in; // see R5
    end
  end

  // Strobe polarity applied with the captured value, not the live strap
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      host_strobe_active <= 1'b0;
    end else begin
      host_strobe_active <= strobe_active_high ? host_strobe_raw : !host_strobe_raw; // see R3
    end
  end

  // Divider runs only in I2C boot, keeping the bit rate under the limit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      i2c_count <= '0;
      i2c_bit_tick <= 1'b0;
    end else begin
      i2c_count <= i2c_run ? i2c_count + `RSCL_I2C_CNT_W'(1) : '0; // see R8
      i2c_bit_tick <= i2c_run && i2c_wrap; // see R8
    end
  end

  // --------------------------------------------------------------------------
  // Checker helper
  // --------------------------------------------------------------------------
  // Cycles since the last tick, kept apart from the divider count
  // so a broken divider cannot vouch for itself
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_gap <= 8'h00;
    end else if (!i2c_run) begin
      tick_gap <= 8'h00;
    end else begin
      tick_gap <= i2c_bit_tick ? 8'h01 : tick_gap + 8'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_capture_on_release: assert property ( // see R1
    $rose(power_on_reset_n) |=> config_valid && boot_mode == $past(boot_mode_strap)
  ) else $error("boot code not captured at reset release");

  chk_watchdog_follows: assert property ( // see R2
    $rose(power_on_reset_n) |=> watchdog_enable == $past(watchdog_enable_strap)
  ) else $error("watchdog enable does not match strap");

  chk_strobe_polarity: assert property ( // see R3
    config_valid && !strobe_active_high && !host_strobe_raw |=> host_strobe_active
  ) else $error("active low strobe not recognised");

  chk_port_width: assert property ( // see R4
    $rose(power_on_reset_n) |=> host_port_8bit == $past(host_port_width_strap)
  ) else $error("host port width does not match strap");

  chk_open_drain_low: assert property ( // see R5
    !hard_reset_pin_out
  ) else $error("hard reset pin driven high");

  chk_pull_in_reset: assert property ( // see R5
    !power_on_reset_n |=> hard_reset_pin_oe
  ) else $error("hard reset pin not pulled during power-on reset");

  chk_let_go_running: assert property ( // see R5
    power_on_reset_n |=> !hard_reset_pin_oe
  ) else $error("hard reset pin still pulled after power-on reset");

  chk_boot_decode: assert property ( // see R6
    $rose(power_on_reset_n) && boot_mode_strap == `RSCL_BM_I2C
      |=> boot_port == rscl_pkg::RSCL_BOOT_I2C
  ) else $error("code 0001 not decoded as I2C boot");

  chk_alt_pins: assert property ( // see R7
    config_valid |-> boot_alt_pins == (boot_mode == `RSCL_BM_SPI_ALT)
  ) else $error("alternate pin flag disagrees with boot code");

  chk_i2c_divider: assert property ( // see R8
    i2c_run |-> i2c_bit_tick == (tick_gap == 8'(`RSCL_I2C_DIV))
  ) else $error("I2C tick spacing is not 128 cycles");

  chk_hold_values: assert property ( // see R9
    config_valid && $past(config_valid) |-> $stable(boot_mode) && $stable(watchdog_enable)
  ) else $error("captured straps changed while running");

  cov_i2c_boot: cover property (config_valid && boot_port == rscl_pkg::RSCL_BOOT_I2C);
  cov_alt_spi: cover property (config_valid && boot_alt_pins);
  cov_rerelease: cover property (config_valid ##1 !config_valid ##[1:20] config_valid);
  cov_reserved: cover property (config_valid && boot_port == rscl_pkg::RSCL_BOOT_RSV);

endmodule

// ==== tb/rscl_board_model.sv ====
// Board side model: strap resistors and an external open-drain reset driver
module rscl_board_model (
  input wire rscl_pkg::rscl_strap_t strap_set, // Strap setting chosen by the bench
  input wire logic ext_reset_low, // External open-drain driver pulling low
  input wire logic pin_oe, // Device pulling the reset pin
  input wire logic pin_out, // Level the device drives
  output rscl_pkg::rscl_strap_t straps, // Levels on the strap pins
  output logic pin_level // Resolved reset pin level
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------------------
  // Resistors always hold a level, so the straps never float
  assign straps = strap_set;
  // Pull-up wins unless some party sinks the line; nobody ever drives high
  assign pin_level = !(ext_reset_low || (pin_oe && !pin_out));
endmodule

// ==== tb/tb_reset_strap_config_latch.sv ====
// Self-checking bench for the reset strap configuration latch
module tb_reset_strap_config_latch;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic por_n = 1'h0;
  logic raw = 1'h0;
  logic ext_low = 1'h0;
  rscl_pkg::rscl_strap_t strap_set = '0;
  rscl_pkg::rscl_strap_t straps;
  rscl_pkg::rscl_boot_t boot_port;
  logic pin_in, pin_out, pin_oe, seen_low, strobe, valid, alt, wd, pol, w8, tick;
  logic [3:0] boot_mode;
  logic [7:0] lfsr = 8'h32;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  // ---------------------------------------------------------------------------
  // Design and board
  // ---------------------------------------------------------------------------
  rscl_strap_latch rscl_strap_latch_inst (.clock(clock), .rst_n(rst_n),
    .power_on_reset_n(por_n), .boot_mode_strap(straps.boot_mode),
    .watchdog_enable_strap(straps.watchdog_enable),
    .host_strobe_polarity_strap(straps.strobe_polarity),
    .host_port_width_strap(straps.port_width), .hard_reset_pin_in(pin_in),
    .hard_reset_pin_out(pin_out), .hard_reset_pin_oe(pin_oe), .hard_reset_seen(seen_low),
    .host_strobe_raw(raw), .host_strobe_active(strobe), .config_valid(valid),
    .boot_mode(boot_mode), .boot_port(boot_port), .boot_alt_pins(alt),
    .watchdog_enable(wd), .strobe_active_high(pol), .host_port_8bit(w8),
    .i2c_bit_tick(tick));
  rscl_board_model rscl_board_model_inst (.strap_set(strap_set), .ext_reset_low(ext_low),
    .pin_oe(pin_oe), .pin_out(pin_out), .straps(straps), .pin_level(pin_in));

  // ---------------------------------------------------------------------------
  // Clock, helpers and hang guard
  // ---------------------------------------------------------------------------
  always #2 clock = ~clock;

  function automatic logic [7:0] next_rand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Boot class expected for each strap code
  function automatic rscl_pkg::rscl_boot_t exp_port(input logic [3:0] c);
    case (c)
      4'h0, 4'h2, 4'h4, 4'h5, 4'h7: return rscl_pkg::RSCL_BOOT_HOST;
      4'h8, 4'h9, 4'hA, 4'hB: return rscl_pkg::RSCL_BOOT_SPI;
      4'hC: return rscl_pkg::RSCL_BOOT_SPI_ALT;
      4'h1: return rscl_pkg::RSCL_BOOT_I2C;
      default: return rscl_pkg::RSCL_BOOT_RSV;
    endcase
  endfunction

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d, miscompared %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [11:0] exp;
    int n;
    repeat (3) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    #1 check(12'({pin_out, pin_oe, pin_in, valid}), 12'h4);
    // Every boot code once, other straps random, then disturb the pins
    for (int c = 0; c < 16; c++) begin
      @(posedge clock);
      lfsr = next_rand(lfsr);
      strap_set <= {c[3:0], lfsr[2:0]};
      por_n <= 1'h0;
      @(posedge clock);
      por_n <= 1'h1;
      @(posedge clock);
      strap_set <= ~strap_set;
      raw <= lfsr[3];
      exp = {c[3:0], 3'(exp_port(c[3:0])), c == 12, lfsr[2:0], 1'h1};
      #1 check({boot_mode, boot_port, alt, wd, pol, w8, valid}, exp);
      check(12'({pin_out, pin_oe}), 12'h0);
      @(posedge clock);
      #1 check({boot_mode, boot_port, alt, wd, pol, w8, valid}, exp);
      check(12'(strobe), 12'(lfsr[3] ^ !lfsr[1]));
      if (c == 1) begin
        // Divide-by-128 tick: first one 128 edges after capture
        n = 0;
        while (!tick && n < 300) begin
          @(posedge clock);
          #1 n++;
        end
        check(12'(n), 12'h07F);
        n = 0;
        do begin
          @(posedge clock);
          #1 n++;
        end while (!tick && n < 300);
        check(12'(n), 12'h080);
      end
      $display("boot code %0h done", c);
    end
    // Power-on reset again: valid drops, captured values stay
    @(posedge clock);
    por_n <= 1'h0;
    @(posedge clock);
    #1 check({boot_mode, boot_port, alt, wd, pol, w8, valid}, {exp[11:1], 1'h0});
    check(12'({pin_oe, pin_in}), 12'h2);
    // Outside driver sinks the pin while the device lets go
    @(posedge clock);
    por_n <= 1'h1;
    @(posedge clock);
    ext_low <= 1'h1;
    @(posedge clock);
    #1 check(12'({pin_in, seen_low}), 12'h1);
    @(posedge clock);
    ext_low <= 1'h0;
    #1 check(12'(seen_low), 12'h1);
    @(posedge clock);
    @(posedge clock);
    #1 check(12'({pin_in, seen_low}), 12'h2);
    $display("reset pin test done");
    conclude();
  end
endmodule
